// [core/fpp_params.svh]
// Constants for the flash partition protection configuration block.
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH
`define FPP_ADDR_CFG 12'h000
`define FPP_ADDR_CTRL 12'h004
`define FPP_ADDR_STAT 12'h008
`define FPP_ADDR_GUARD 12'h00c
`define FPP_BIT_LVP 13
`define FPP_BIT_SAFWP 11
`define FPP_BIT_CFGWP 9
`define FPP_BIT_BOOTWP 8
`define FPP_BIT_APPWP 7
`define FPP_BIT_STORAGE_AREA_ENABLE_N 4
`define FPP_BIT_BOOTEN 3
`define FPP_CFG_ERASED 14'h3fff
`define FPP_CFG_UNIMPL 14'h1460
`define FPP_WORD_W 14
`define FPP_PROG_MEM_WORDS 16384
`define FPP_SAF_WORDS 128
`define FPP_BOOT_MIN 512
`define FPP_RESP_OKAY 2'b00
`define FPP_RESP_SLVERR 2'b10
`define FPP_RESP_DECERR 2'b11
`endif

// [core/fpp_pkg.sv]
// Types for the flash partition protection configuration block.
package fpp_pkg;
	typedef struct packed {
		logic low_voltage_prog_enable;
		logic storage_area_write_protect;
		logic config_region_write_protect;
		logic boot_region_write_protect;
		logic app_region_write_protect;
		logic storage_area_enable_n;
		logic boot_region_enable_n;
		logic [2:0] boot_region_size_sel;
	} fpp_cfg_type;

	typedef struct packed {
		logic boot_hit;
		logic saf_hit;
		logic cfg_hit;
		logic app_hit;
	} fpp_region_type;

	typedef enum logic [1:0] {
		FPP_IDLE = 2'b00,
		FPP_RESP = 2'b01
	} fpp_bus_state_type;
endpackage

// [core/fpp_region_decode.sv]
// Address to region decoder for program flash self-writes.
`timescale 1ns/10ps
`include "fpp_params.svh"
module fpp_region_decode #(
	parameter int MEM_WORDS = `FPP_PROG_MEM_WORDS
) (
	input wire fpp_pkg::fpp_cfg_type cfg,
	input wire logic is_config_space,
	input wire logic [14:0] addr,
	output fpp_pkg::fpp_region_type region,
	output logic [14:0] boot_words
);
	logic [14:0] sel_words;
	logic [14:0] half_words;

	always_comb begin
		// Size codes below 100 all select the largest boot block.
		case (cfg.boot_region_size_sel)
			3'h7: sel_words = 15'(`FPP_BOOT_MIN);
			3'h6: sel_words = 15'(`FPP_BOOT_MIN * 2);
			3'h5: sel_words = 15'(`FPP_BOOT_MIN * 4);
			3'h4: sel_words = 15'(`FPP_BOOT_MIN * 8);
			default: sel_words = 15'(`FPP_BOOT_MIN * 16);
		endcase
		half_words = 15'(MEM_WORDS / 2);
		if (cfg.boot_region_enable_n) begin
			boot_words = 15'h0000;
		end else if (sel_words > half_words) begin
			boot_words = half_words;
		end else begin
			boot_words = sel_words;
		end
		region.cfg_hit = is_config_space;
		region.boot_hit = !is_config_space && (addr < boot_words);
		// The storage area sits at the top of memory only when it is enabled.
		region.saf_hit = !is_config_space && !cfg.storage_area_enable_n
			&& (addr >= 15'(MEM_WORDS - `FPP_SAF_WORDS)) && (addr < 15'(MEM_WORDS));
		region.app_hit = !is_config_space && !region.boot_hit && !region.saf_hit
			&& (addr < 15'(MEM_WORDS));
	end
endmodule

// [core/fpp_config_top.sv]
// Memory partition configuration word with AXI4-Lite access and write guard.
//
// Overview of operation
// - Low voltage programming enabled makes the shared pin a pure reset input.
// - Low voltage programming disabled allows entry only via high voltage pin level.
// - Clearing low voltage enable is refused while programming over low voltage.
// - Storage area protect, 0 protects, effective only when storage area enabled.
// - Configuration protect bit 0 blocks self-writes to configuration words.
// - Boot protect bit 0 protects boot block, only when boot block enabled.
// - Application protect bit 0 protects the application region.
// - Storage area enable low creates the storage partition.
// - Boot enable high forces boot size to zero.
// - Boot size field matters only while boot block is enabled.
// - Boot size field writable only while boot block is disabled.
// - Protection and enable bits are sticky; only bulk erase or reset releases them.
// - Size codes 111..100 give 512..4096 words; lower codes give 8192.
// - Boot block is clamped to half of user program memory.
// - Protection guards only self-writes from the running program.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "fpp_params.svh"
module fpp_config_top #(
	parameter int MEM_WORDS = `FPP_PROG_MEM_WORDS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic master_clear_pin,
	input wire logic high_voltage_detect,
	input wire logic lvp_entry_request,
	input wire logic master_clear_pin_enable,
	input wire logic self_write_req,
	input wire logic self_write_is_config,
	input wire logic [14:0] self_write_addr,
	output logic self_write_grant,
	output logic self_write_blocked,
	output logic device_reset_req,
	output logic prog_mode_active,
	output fpp_pkg::fpp_cfg_type cfg_out
);
	fpp_pkg::fpp_cfg_type cfg;
	fpp_pkg::fpp_region_type region;
	fpp_pkg::fpp_bus_state_type wstate;
	logic [14:0] boot_words;
	logic [13:0] cfg_word;
	logic [11:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic wr_go;
	logic refused_cnt_inc;
	logic [7:0] refused_cnt;
	logic [1:0] master_clear_pin_sync;
	logic [1:0] hv_sync;
	logic [1:0] lvp_req_sync;
	logic prog_lvp;
	logic prog_hv;
	logic bulk_erase;
	logic wr_fault;

	// Pins from outside pass two flip-flops before use.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_clear_pin_sync <= 2'h3;
			hv_sync <= 2'h0;
			lvp_req_sync <= 2'h0;
		end else begin
			master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin};
			hv_sync <= {hv_sync[0], high_voltage_detect};
			lvp_req_sync <= {lvp_req_sync[0], lvp_entry_request};
		end
	end

	// Reset function of the shared pin; enable setting is ignored under low voltage mode.
	always_comb begin
		if (cfg.low_voltage_prog_enable) begin
			device_reset_req = !master_clear_pin_sync[1];
		end else begin
			device_reset_req = master_clear_pin_enable && !master_clear_pin_sync[1];
		end
	end

	// Programming entry selection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_lvp <= 1'b0;
			prog_hv <= 1'b0;
		end else begin
			prog_lvp <= cfg.low_voltage_prog_enable && lvp_req_sync[1];
			prog_hv <= hv_sync[1];
		end
	end
	assign prog_mode_active = prog_lvp || prog_hv;

	// AXI write channel capture, address and data in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_held && (wstate == fpp_pkg::FPP_IDLE);
	assign s_axi_wready = !w_held && (wstate == fpp_pkg::FPP_IDLE);
	assign wr_go = aw_held && w_held && (wstate == fpp_pkg::FPP_IDLE);
	assign bulk_erase = wr_go && aw_addr == `FPP_ADDR_CTRL && w_strb[0] && w_data[0];

	// Configuration word update with sticky protection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= fpp_pkg::fpp_cfg_type'(10'h3ff);
			wr_fault <= 1'b0;
		end else if (bulk_erase) begin
			cfg <= fpp_pkg::fpp_cfg_type'(10'h3ff);
			wr_fault <= 1'b0;
		end else if (wr_go && aw_addr == `FPP_ADDR_CFG && w_strb[1:0] == 2'h3) begin
			// Zeros may be written, ones only by bulk erase; the size field takes any value while boot is disabled.
			cfg.storage_area_write_protect <= cfg.storage_area_write_protect
				& w_data[`FPP_BIT_SAFWP];
			cfg.config_region_write_protect <= cfg.config_region_write_protect
				& w_data[`FPP_BIT_CFGWP];
			cfg.boot_region_write_protect <= cfg.boot_region_write_protect
				& w_data[`FPP_BIT_BOOTWP];
			cfg.app_region_write_protect <= cfg.app_region_write_protect
				& w_data[`FPP_BIT_APPWP];
			cfg.storage_area_enable_n <= cfg.storage_area_enable_n & w_data[`FPP_BIT_STORAGE_AREA_ENABLE_N];
			cfg.boot_region_enable_n <= cfg.boot_region_enable_n & w_data[`FPP_BIT_BOOTEN];
			if (cfg.boot_region_enable_n) begin
				cfg.boot_region_size_sel <= w_data[2:0];
			end
			if (prog_lvp && !w_data[`FPP_BIT_LVP]) begin
				wr_fault <= 1'b1;
			end else begin
				cfg.low_voltage_prog_enable <= cfg.low_voltage_prog_enable
					& w_data[`FPP_BIT_LVP];
			end
		end
	end
	assign cfg_out = cfg;

	always_comb begin
		cfg_word = `FPP_CFG_UNIMPL | 14'(1 << `FPP_BIT_LVP);
		cfg_word[`FPP_BIT_LVP] = cfg.low_voltage_prog_enable;
		cfg_word[`FPP_BIT_SAFWP] = cfg.storage_area_write_protect;
		cfg_word[`FPP_BIT_CFGWP] = cfg.config_region_write_protect;
		cfg_word[`FPP_BIT_BOOTWP] = cfg.boot_region_write_protect;
		cfg_word[`FPP_BIT_APPWP] = cfg.app_region_write_protect;
		cfg_word[`FPP_BIT_STORAGE_AREA_ENABLE_N] = cfg.storage_area_enable_n;
		cfg_word[`FPP_BIT_BOOTEN] = cfg.boot_region_enable_n;
		cfg_word[2:0] = cfg.boot_region_size_sel;
	end

	fpp_region_decode #(
		.MEM_WORDS(MEM_WORDS)
	) u_decode (
		.cfg(cfg),
		.is_config_space(self_write_is_config),
		.addr(self_write_addr),
		.region(region),
		.boot_words(boot_words)
	);

	// Self-write guard; external programming paths never consult it.
	always_comb begin
		self_write_blocked = 1'b0;
		if (self_write_req && !prog_mode_active) begin
			self_write_blocked =
				(region.saf_hit && !cfg.storage_area_write_protect)
				|| (region.cfg_hit && !cfg.config_region_write_protect)
				|| (region.boot_hit && !cfg.boot_region_write_protect)
				|| (region.app_hit && !cfg.app_region_write_protect)
				|| (!region.cfg_hit && !region.saf_hit && !region.boot_hit
					&& !region.app_hit);
		end
	end
	assign self_write_grant = self_write_req && !self_write_blocked;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refused_cnt <= 8'h00;
		end else if (bulk_erase) begin
			refused_cnt <= 8'h00;
		end else if (refused_cnt_inc && refused_cnt != 8'hff) begin
			refused_cnt <= refused_cnt + 8'h01;
		end
	end
	assign refused_cnt_inc = self_write_blocked;

	// Write response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate <= fpp_pkg::FPP_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FPP_RESP_OKAY;
		end else begin
			case (wstate)
				fpp_pkg::FPP_IDLE: begin
					if (wr_go) begin
						wstate <= fpp_pkg::FPP_RESP;
						s_axi_bvalid <= 1'b1;
						if (aw_addr == `FPP_ADDR_CFG || aw_addr == `FPP_ADDR_CTRL) begin
							s_axi_bresp <= `FPP_RESP_OKAY;
						end else if (aw_addr == `FPP_ADDR_STAT
							|| aw_addr == `FPP_ADDR_GUARD) begin
							s_axi_bresp <= `FPP_RESP_SLVERR;
						end else begin
							s_axi_bresp <= `FPP_RESP_DECERR;
						end
					end
				end
				fpp_pkg::FPP_RESP: begin
					if (s_axi_bready) begin
						wstate <= fpp_pkg::FPP_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wstate <= fpp_pkg::FPP_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// Read channel, one cycle to answer.
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `FPP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `FPP_RESP_OKAY;
			case (s_axi_araddr)
				`FPP_ADDR_CFG: s_axi_rdata <= {18'h00000, cfg_word};
				`FPP_ADDR_CTRL: s_axi_rdata <= 32'h00000000;
				`FPP_ADDR_STAT: s_axi_rdata <= {28'h0000000, wr_fault, prog_hv, prog_lvp,
					device_reset_req};
				`FPP_ADDR_GUARD: s_axi_rdata <= {9'h000, refused_cnt, boot_words};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `FPP_RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Application protect never rises except through bulk erase or reset.
	chk_sticky_protect: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cfg.app_region_write_protect) |-> $past(bulk_erase) || !$past(aresetn))
		else $error("Application protect released without bulk erase.");
	chk_lvp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(cfg.low_voltage_prog_enable) |-> !$past(prog_lvp))
		else $error("Low voltage enable cleared during low voltage programming.");
	chk_size_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg.boot_region_enable_n && !$past(bulk_erase) && $past(!cfg.boot_region_enable_n)
		|-> $stable(cfg.boot_region_size_sel))
		else $error("Boot size changed while boot block enabled.");
	chk_boot_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg.boot_region_enable_n |-> boot_words == 15'h0000)
		else $error("Boot size not zero while boot block disabled.");
	chk_boot_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
		boot_words <= 15'(MEM_WORDS / 2))
		else $error("Boot block exceeds half of memory.");
	chk_app_block: assert property (@(posedge aclk) disable iff (!aresetn)
		self_write_req && !prog_mode_active && region.app_hit
		&& !cfg.app_region_write_protect |-> !self_write_grant)
		else $error("Write to protected application region granted.");
	chk_cfg_block: assert property (@(posedge aclk) disable iff (!aresetn)
		self_write_req && !prog_mode_active && self_write_is_config
		&& !cfg.config_region_write_protect |-> self_write_blocked)
		else $error("Write to protected configuration granted.");
	chk_reset_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg.low_voltage_prog_enable && !$past(master_clear_pin, 2) |-> device_reset_req)
		else $error("Shared pin did not reset under low voltage mode.");
	chk_hv_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg.low_voltage_prog_enable ##1 $rose(prog_mode_active) |-> prog_hv)
		else $error("Programming entered without high voltage.");
endmodule

// [verification/tb.sv]
// Self-checking bench for the flash partition protection configuration block.
`timescale 1ns/10ps
`include "fpp_params.svh"
module tb;
	// A small memory makes the half-memory clamp reachable with the lower size codes.
	localparam int MEM = 8192;
	logic aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic master_clear_pin, high_voltage_detect, lvp_entry_request, master_clear_pin_enable;
	logic self_write_req, self_write_is_config, self_write_grant, self_write_blocked;
	logic [14:0] self_write_addr;
	logic device_reset_req, prog_mode_active;
	fpp_pkg::fpp_cfg_type cfg_out;
	int error_cnt, n_tests, i;
	int cyc = 0;
	logic [31:0] rd;
	logic [1:0] rsp;

	fpp_config_top #(.MEM_WORDS(MEM)) fpp_config_top_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .master_clear_pin(master_clear_pin),
		.high_voltage_detect(high_voltage_detect), .lvp_entry_request(lvp_entry_request),
		.master_clear_pin_enable(master_clear_pin_enable), .self_write_req(self_write_req),
		.self_write_is_config(self_write_is_config), .self_write_addr(self_write_addr),
		.self_write_grant(self_write_grant), .self_write_blocked(self_write_blocked),
		.device_reset_req(device_reset_req), .prog_mode_active(prog_mode_active),
		.cfg_out(cfg_out)
	);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		$display("checks=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Ready is sampled at the falling edge so the decision never races the design's edge.
	task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_go, w_go, aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge aclk);
			aw_go = s_axi_awready;
			w_go = s_axi_wready;
			@(posedge aclk);
			if (aw_go === 1'b1 && !aw_done) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (w_go === 1'b1 && !w_done) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		@(posedge aclk);
	endtask

	task axi_rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge aclk);
	endtask

	task wcfg(input logic [13:0] v);
		axi_wr(`FPP_ADDR_CFG, {18'h0, v}, 4'hf);
	endtask

	task erase;
		axi_wr(`FPP_ADDR_CTRL, 32'h1, 4'h1);
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_rd(a);
		chk(rd & m, e);
	endtask

	// Expected pattern is {grant, blocked}; both outputs are combinational.
	task sw(input logic [14:0] a, input logic c, input logic [1:0] e);
		self_write_req <= 1'b1;
		self_write_addr <= a;
		self_write_is_config <= c;
		@(negedge aclk);
		chk({30'h0, self_write_grant, self_write_blocked}, {30'h0, e});
		@(posedge aclk);
		self_write_req <= 1'b0;
		@(posedge aclk);
	endtask

	// Pin inputs pass a synchroniser, so the flag is given a few cycles to follow.
	task wait_flag(input logic sel, input logic lvl);
		i = 0;
		do begin
			@(negedge aclk);
			i++;
		end while (i < 8 && (sel ? prog_mode_active : device_reset_req) !== lvl);
		chk({31'h0, sel ? prog_mode_active : device_reset_req}, {31'h0, lvl});
		@(posedge aclk);
	endtask

	function automatic logic [31:0] boot_exp(input logic [2:0] c);
		logic [31:0] w;
		w = c[2] ? (32'h200 << (3'h7 - c)) : 32'h2000;
		return (w > 32'(MEM / 2)) ? 32'(MEM / 2) : w;
	endfunction

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 12'h0;
		s_axi_araddr = 12'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		master_clear_pin = 1'b1;
		high_voltage_detect = 1'b0;
		lvp_entry_request = 1'b0;
		master_clear_pin_enable = 1'b1;
		self_write_req = 1'b0;
		self_write_is_config = 1'b0;
		self_write_addr = 15'h0;
		error_cnt = 0;
		n_tests = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({22'h0, cfg_out}, 32'h3ff);
		rchk(`FPP_ADDR_CFG, 32'h3fff, 32'h3fff);
		rchk(`FPP_ADDR_GUARD, 32'h7fff, 32'h0);
		for (int c = 0; c < 8; c++) begin
			erase();
			wcfg(14'h3ff8 | 14'(c));
			rchk(`FPP_ADDR_GUARD, 32'h7fff, 32'h0);
			wcfg(14'h3ff0 | 14'(c));
			rchk(`FPP_ADDR_GUARD, 32'h7fff, boot_exp(3'(c)));
		end
		wcfg(14'h3ff0);
		rchk(`FPP_ADDR_GUARD, 32'h7fff, 32'h200);
		wcfg(14'h3fff);
		rchk(`FPP_ADDR_CFG, 32'h3fff, 32'h3ff7);
		sw(15'h100, 1'b0, 2'b10);
		wcfg(14'h3ef7);
		sw(15'h100, 1'b0, 2'b01);
		sw(15'h1000, 1'b0, 2'b10);
		sw(15'h2000, 1'b0, 2'b01);
		sw(15'h1000, 1'b1, 2'b10);
		wcfg(14'h3cf7);
		sw(15'h1000, 1'b1, 2'b01);
		wcfg(14'h3c77);
		sw(15'h1000, 1'b0, 2'b01);
		erase();
		wcfg(14'h3eff);
		sw(15'h0, 1'b0, 2'b10);
		wcfg(14'h37ff);
		sw(15'h1f90, 1'b0, 2'b10);
		wcfg(14'h37ef);
		sw(15'h1f90, 1'b0, 2'b01);
		sw(15'h1f7f, 1'b0, 2'b10);
		rchk(`FPP_ADDR_GUARD, 32'h7fffff, 32'h8000);
		axi_wr(`FPP_ADDR_STAT, 32'h0, 4'hf);
		chk({30'h0, rsp}, {30'h0, `FPP_RESP_SLVERR});
		axi_rd(12'h010);
		chk({30'h0, rsp}, {30'h0, `FPP_RESP_DECERR});
		axi_wr(12'h010, 32'h0, 4'hf);
		chk({30'h0, rsp}, {30'h0, `FPP_RESP_DECERR});
		erase();
		master_clear_pin_enable <= 1'b0;
		master_clear_pin <= 1'b0;
		wait_flag(1'b0, 1'b1);
		master_clear_pin <= 1'b1;
		lvp_entry_request <= 1'b1;
		wait_flag(1'b1, 1'b1);
		wcfg(14'h1f7f);
		rchk(`FPP_ADDR_CFG, 32'h3fff, 32'h3f7f);
		rchk(`FPP_ADDR_STAT, 32'he, 32'ha);
		sw(15'h1000, 1'b0, 2'b10);
		lvp_entry_request <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wcfg(14'h1fff);
		rchk(`FPP_ADDR_CFG, 32'h3fff, 32'h1fff);
		lvp_entry_request <= 1'b1;
		repeat (8) @(posedge aclk);
		wait_flag(1'b1, 1'b0);
		high_voltage_detect <= 1'b1;
		wait_flag(1'b1, 1'b1);
		report_and_stop();
	end
endmodule
